//--- dv/sdac_properties.sv
// Assertions on the ports of the serial input block
`timescale 1ns/1ps
`default_nettype none
module sdac_properties
  import sdac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic audio_bit_clock,
  input wire logic lr_clock,
  input wire logic serial_audio_in,
  input wire logic audio_format_sel0,
  input wire logic audio_format_sel1,
  input wire logic word_len_18,
  input wire logic control_shift_clock,
  input wire logic control_serial_in,
  input wire logic control_load_strobe,
  input wire logic powerdown_reset_n,
  input wire sdac_pair_t sampleData,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic sampleOverrun,
  input wire sdac_ctl_t channelSetting,
  input wire logic frameTick
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
////////////////////////////////////////////////////////////////////////////////
  property p_tick; $rose(lr_clock) |-> ##[1:5] frameTick; endproperty
  a_tick: assert property (p_tick) else $error("frame tick late");
  property p_pulse; frameTick |=> !frameTick; endproperty
  a_pulse: assert property (p_pulse) else $error("frame tick too long");
  property p_hold; sampleValid && !sampleReady |=> sampleValid && $stable(sampleData); endproperty
  a_hold: assert property (p_hold) else $error("waiting pair lost");
  property p_short; !word_len_18 && sampleValid |-> sampleData.left[1:0] == 2'h0 &&
    sampleData.right[1:0] == 2'h0; endproperty
  a_short: assert property (p_short) else $error("short word not aligned");
  property p_pd; !powerdown_reset_n [*6] |-> channelSetting == 16'h0000; endproperty
  a_pd: assert property (p_pd) else $error("settings kept in power-down");
  // Outside power-down a setting may only move shortly after a strobe rise has been seen
  property p_chg; powerdown_reset_n && !$stable(channelSetting) |->
    $past(control_load_strobe, 2); endproperty
  a_chg: assert property (p_chg) else $error("setting moved without strobe");
  property p_lvl; control_load_strobe [*8] |=> $stable(channelSetting); endproperty
  a_lvl: assert property (p_lvl) else $error("strobe level acted on");
  property p_fall; $fell(control_load_strobe) |-> $stable(channelSetting) [*6]; endproperty
  a_fall: assert property (p_fall) else $error("strobe fall acted on");
  c_ovr: cover property (sampleOverrun);
  c_pop: cover property (sampleValid && sampleReady);
  c_ctl: cover property (!$stable(channelSetting));
endmodule
`default_nettype wire

//--- dv/sdac_source.sv
// Model of the audio source and the control host
`timescale 1ns/1ps
`default_nettype none
module sdac_source (
  output var logic audio_bit_clock = 1'b0,
  output var logic lr_clock = 1'b1,
  output var logic serial_audio_in = 1'b0,
  output var logic control_shift_clock = 1'b0,
  output var logic control_serial_in = 1'b0,
  output var logic control_load_strobe = 1'b0
);
  // Bit clock runs only inside a frame; pad bits are ones to expose misalignment
  task automatic frame(input logic [1:0] fmt, input logic wl, input logic [17:0] l, r);
    int n, off, p;
    n = wl ? 18 : 16;
    off = fmt == 2'h2 ? 32 - n : int'(fmt == 2'h1);
    #3.3;
    for (int h = 0; h < 2; h++) begin
      for (int k = 0; k < off + n; k++) begin
        p = k - off;
        lr_clock <= fmt == 2'h3 ? (h == 0 && k == 0) : h == 0;
        serial_audio_in <= p < 0 ? 1'b1 : (h == 1 ? r[17 - p] : l[17 - p]);
        #15 audio_bit_clock <= 1'b1;
        #15 audio_bit_clock <= 1'b0;
      end
    end
    serial_audio_in <= ~serial_audio_in;
    #15 audio_bit_clock <= 1'b1;
    #15 audio_bit_clock <= 1'b0;
    lr_clock <= 1'b1;
  endtask
  task automatic ctl(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      control_serial_in <= v[i];
      #40 control_shift_clock <= 1'b1;
      #40 control_shift_clock <= 1'b0;
    end
    control_serial_in <= ~v[0];
    #40 control_load_strobe <= 1'b1;
    #100 control_load_strobe <= 1'b0;
    #40;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench of the serial input block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top import sdac_pkg::*; ;
  typedef struct packed {logic [1:0] fmt; logic wl; logic [17:0] l; logic [17:0] r;} sdac_row_t;
  logic clk_sys = 1'b0, rstn = 1'b0, audio_format_sel0 = 1'b0, audio_format_sel1 = 1'b0;
  logic word_len_18 = 1'b1, powerdown_reset_n = 1'b1, sampleReady = 1'b0, ovrSeen = 1'b0;
  logic audio_bit_clock, lr_clock, serial_audio_in, control_shift_clock, control_serial_in;
  logic control_load_strobe, sampleValid, sampleOverrun, frameTick;
  logic [17:0] m;
  sdac_pair_t sampleData;
  sdac_ctl_t channelSetting, ce;
  int errors = 0, samplesChecked = 0;
  int ticks = 0, tickBase = 0;
  sdac_row_t rows [8] = '{
    '{2'h0, 1'b1, 18'h2A5C3, 18'h1F00F}, '{2'h1, 1'b1, 18'h3FFFF, 18'h00001},
    '{2'h2, 1'b1, 18'h20001, 18'h15A5A}, '{2'h3, 1'b1, 18'h0F0F0, 18'h3C3C3},
    '{2'h0, 1'b0, 18'h35554, 18'h0AAA8}, '{2'h1, 1'b0, 18'h20000, 18'h1FFFC},
    '{2'h2, 1'b0, 18'h3FFFC, 18'h12344}, '{2'h3, 1'b0, 18'h0C3F0, 18'h2DB6C}};
  logic [7:0] cv [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
  sdac_serial_in i_sdac_serial_in (.clk_sys, .rstn, .audio_bit_clock, .lr_clock,
    .serial_audio_in, .audio_format_sel0, .audio_format_sel1, .word_len_18,
    .control_shift_clock, .control_serial_in, .control_load_strobe, .powerdown_reset_n,
    .sampleData, .sampleValid, .sampleReady, .sampleOverrun, .channelSetting, .frameTick);
  sdac_source i_sdac_source (.audio_bit_clock, .lr_clock, .serial_audio_in,
    .control_shift_clock, .control_serial_in, .control_load_strobe);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  always @(posedge clk_sys) if (sampleOverrun === 1'b1) ovrSeen <= 1'b1;
  always @(posedge clk_sys) if (frameTick === 1'b1) ticks <= ticks + 1;
////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("errors %0d samplesChecked %0d", errors, samplesChecked);
    if (errors == 0 && samplesChecked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Read on the falling edge so the pair has settled; pop takes one cycle
  task automatic pop(input sdac_pair_t e);
    @(negedge clk_sys);
    for (int n = 0; n < 300 && sampleValid !== 1'b1; n++) @(negedge clk_sys);
    `CHK("popValid", 1'b1, sampleValid)
    `CHK("pair", e, sampleData)
    @(posedge clk_sys) sampleReady <= 1'b1;
    @(posedge clk_sys) sampleReady <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    tickBase = ticks;
    foreach (rows[i]) begin
      @(posedge clk_sys) {audio_format_sel1, audio_format_sel0} <= rows[i].fmt;
      word_len_18 <= rows[i].wl;
      @(posedge clk_sys);
      i_sdac_source.frame(rows[i].fmt, rows[i].wl, rows[i].l, rows[i].r);
      m = rows[i].wl ? 18'h3FFFF : 18'h3FFFC;
      pop({rows[i].l & m, rows[i].r & m});
    end
    repeat (8) @(posedge clk_sys);
    `CHK("ticks", tickBase + 8, ticks)
    `CHK("ovrIdle", 1'b0, ovrSeen)
    @(posedge clk_sys) {audio_format_sel1, audio_format_sel0} <= 2'h0;
    word_len_18 <= 1'b1;
    // Sixteen fill the buffer, one waits, the last overwrites the waiting one
    for (int i = 0; i < 18; i++) i_sdac_source.frame(2'h0, 1'b1, 18'(i), 18'(i + 99));
    for (int i = 0; i < 17; i++) pop({18'(i + i / 16), 18'(i + i / 16 + 99)});
    `CHK("ovr", 1'b1, ovrSeen)
    @(negedge clk_sys) `CHK("empty", 1'b0, sampleValid)
    ce = '0;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) begin
        @(posedge clk_sys) powerdown_reset_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        powerdown_reset_n <= 1'b1;
        ce = '0;
        repeat (5) @(negedge clk_sys);
        `CHK("pdClear", ce, channelSetting)
      end
      i_sdac_source.ctl(cv[i]);
      if (i == 1) ce.right = cv[i];
      else ce.left = cv[i];
      @(negedge clk_sys) `CHK("ctl", ce, channelSetting)
    end
    i_sdac_source.frame(2'h0, 1'b1, 18'h00001, 18'h00002);
    repeat (10) @(negedge clk_sys);
    `CHK("heldVal", 1'b1, sampleValid)
    `CHK("heldPair", {18'h00001, 18'h00002}, sampleData)
    @(posedge clk_sys) rstn <= 1'b0;
    @(negedge clk_sys) `CHK("rstCtl", 16'h0000, channelSetting)
    `CHK("rstVal", 1'b0, sampleValid)
    stop_test();
  end
endmodule
bind sdac_serial_in sdac_properties i_sdac_properties (.clk_sys, .rstn, .audio_bit_clock,
  .lr_clock, .serial_audio_in, .audio_format_sel0, .audio_format_sel1, .word_len_18,
  .control_shift_clock, .control_serial_in, .control_load_strobe, .powerdown_reset_n,
  .sampleData, .sampleValid, .sampleReady, .sampleOverrun, .channelSetting, .frameTick);
`default_nettype wire

//--- hdl/sdac_defs.svh
// Constants for the stereo converter serial input ports
`ifndef SDAC_DEFS_SVH
`define SDAC_DEFS_SVH
`define SDAC_WORD_W 18
`define SDAC_SHORT_W 16
`define SDAC_SLOT_W 32
`define SDAC_CTL_W 8
`define SDAC_FIFO_DEPTH 16
`define SDAC_ATTEN_RST 8'h00
`define SDAC_FMT_LEFT 2'h0
`define SDAC_FMT_I2S 2'h1
`define SDAC_FMT_RIGHT 2'h2
`define SDAC_FMT_DSP 2'h3
`endif

//--- hdl/sdac_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdac_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_reg];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- hdl/sdac_pkg.sv
// Types shared by the stereo converter serial input ports
`include "sdac_defs.svh"
package sdac_pkg;
  typedef enum logic [1:0] {
    SDAC_LEFT_JUST = `SDAC_FMT_LEFT,
    SDAC_I2S_JUST = `SDAC_FMT_I2S,
    SDAC_RIGHT_JUST = `SDAC_FMT_RIGHT,
    SDAC_DSP_MODE = `SDAC_FMT_DSP
  } sdac_fmt_t;
  typedef struct packed {
    logic [`SDAC_WORD_W-1:0] left;
    logic [`SDAC_WORD_W-1:0] right;
  } sdac_pair_t;
  typedef struct packed {
    logic [`SDAC_CTL_W-1:0] left;
    logic [`SDAC_CTL_W-1:0] right;
  } sdac_ctl_t;
endpackage

//--- hdl/sdac_serial_in.sv
// Serial audio and control input ports of the stereo converter
// How it works
// - Two channels per frame, twos-complement 16 or 18 bits, MSB first.
// - Word length select high means 18-bit words, low means 16-bit.
// - Two format selects decode together as a 2-bit format code.
// - Bit clock may stop or burst; nothing relies on it running.
// - Control words are unsigned 8-bit values sent MSB first.
// - Each control word sets attenuation and mute of one channel.
// - Control data is sampled on the control clock rising edge.
// - Control clock may run continuously or only during a word.
// - Load strobe acts only at its rising edge.
// - Left/right clock frames words and is the sample-rate reference.
// - Bit clock shifts data and samples the left/right clock; frame edges are taken on its rising edge.
// - Formats: left-justified, I2S, right-justified and DSP style.
// - Power-down/reset low returns control settings to defaults.
`timescale 1ns/1ps
`default_nettype none
`include "sdac_defs.svh"
module sdac_serial_in
  import sdac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic audio_bit_clock,
  input wire logic lr_clock,
  input wire logic serial_audio_in,
  input wire logic audio_format_sel0,
  input wire logic audio_format_sel1,
  input wire logic word_len_18,
  input wire logic control_shift_clock,
  input wire logic control_serial_in,
  input wire logic control_load_strobe,
  input wire logic powerdown_reset_n,
  output sdac_pair_t sampleData,
  output logic sampleValid,
  input wire logic sampleReady,
  output logic sampleOverrun,
  output sdac_ctl_t channelSetting,
  output logic frameTick
);
  ////////////////////////////////////////////////////////////////////////////
  // Link domain: bit clock shifts data and frame level; it may stop at will
  logic [`SDAC_WORD_W-1:0] shLeft_reg;
  logic [`SDAC_WORD_W-1:0] shRight_reg;
  logic [5:0] bitCnt_reg;
  logic lrPrev_reg;
  sdac_pair_t hold_reg;
  logic holdTgl_reg;
  sdac_fmt_t fmtLink;
  logic lenLink;
  logic [5:0] wordLen;
  logic [5:0] skip;
  logic [5:0] bitPos;
  logic [5:0] lastPos;
  logic [`SDAC_WORD_W-1:0] rightWord;
  logic frameStart;
  logic inWord;
  logic curLeft;
  logic lrEdge;
  assign fmtLink = sdac_fmt_t'({audio_format_sel1, audio_format_sel0});
  assign lenLink = word_len_18;
  assign wordLen = lenLink ? 6'(`SDAC_WORD_W) : 6'(`SDAC_SHORT_W);
  assign lrEdge = (lr_clock != lrPrev_reg);
  // DSP style restarts only on the rise, the others on either level change
  assign frameStart = lrEdge && (fmtLink != SDAC_DSP_MODE || lr_clock);
  // The bit taken at the frame edge is position zero of the new slot
  assign bitPos = frameStart ? 6'h00 : bitCnt_reg;

  // Bits to skip after the frame edge before the MSB arrives
  always_comb begin
    skip = 6'h00;
    unique case (fmtLink)
      SDAC_LEFT_JUST: skip = 6'h00;
      SDAC_I2S_JUST: skip = 6'h01;
      SDAC_RIGHT_JUST: skip = 6'(`SDAC_SLOT_W) - wordLen;
      SDAC_DSP_MODE: skip = 6'h00;
    endcase
  end

  // In DSP style both words follow one frame pulse back to back
  assign curLeft = (fmtLink == SDAC_DSP_MODE) ? (bitPos < wordLen) : lr_clock;
  assign inWord = (fmtLink == SDAC_DSP_MODE) ? (bitPos < (wordLen << 1)) :
                  ((bitPos >= skip) && (bitPos < skip + wordLen));
  assign lastPos = ((fmtLink == SDAC_DSP_MODE) ? (wordLen << 1) : (skip + wordLen)) - 6'h01;
  assign rightWord = {shRight_reg[`SDAC_WORD_W-2:0], serial_audio_in};

  // Counter resets saturated so nothing is taken before the first frame edge
  always_ff @(posedge audio_bit_clock or negedge rstn) begin
    if (!rstn) begin
      bitCnt_reg <= 6'h3F;
      lrPrev_reg <= 1'b0;
    end else begin
      lrPrev_reg <= lr_clock;
      if (bitPos != 6'h3F) begin
        bitCnt_reg <= bitPos + 6'h01;
      end
    end
  end

  // MSB first, left-aligned in the 18-bit word; 16-bit words pad low
  always_ff @(posedge audio_bit_clock or negedge rstn) begin
    if (!rstn) begin
      shLeft_reg <= '0;
      shRight_reg <= '0;
    end else if (inWord) begin
      if (curLeft) begin
        shLeft_reg <= {shLeft_reg[`SDAC_WORD_W-2:0], serial_audio_in};
      end else begin
        shRight_reg <= rightWord;
      end
    end
  end

  // Capture with the right word's last bit, so no trailing bit clock is needed
  always_ff @(posedge audio_bit_clock or negedge rstn) begin
    if (!rstn) begin
      hold_reg <= '0;
      holdTgl_reg <= 1'b0;
    end else if (inWord && !curLeft && (bitPos == lastPos)) begin
      hold_reg.left <= lenLink ? shLeft_reg : {shLeft_reg[`SDAC_SHORT_W-1:0], 2'b00};
      hold_reg.right <= lenLink ? rightWord : {rightWord[`SDAC_SHORT_W-1:0], 2'b00};
      holdTgl_reg <= ~holdTgl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain: toggle crossing, then the pair waits until the toggle
  // settles; the hold register is stable for a whole frame after it
  logic [2:0] tglSync_reg;
  logic pairPulse;
  logic fifoInReady;
  sdac_pair_t pair_reg;
  logic pairValid_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tglSync_reg <= 3'h0;
    end else begin
      tglSync_reg <= {tglSync_reg[1:0], holdTgl_reg};
    end
  end
  assign pairPulse = tglSync_reg[2] ^ tglSync_reg[1];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pair_reg <= '0;
      pairValid_reg <= 1'b0;
      sampleOverrun <= 1'b0;
    end else begin
      if (pairPulse) begin
        pair_reg <= hold_reg;
        pairValid_reg <= 1'b1;
        sampleOverrun <= pairValid_reg && !fifoInReady;
      end else if (fifoInReady) begin
        pairValid_reg <= 1'b0;
        sampleOverrun <= 1'b0;
      end else begin
        sampleOverrun <= 1'b0;
      end
    end
  end
  sdac_fifo #(.WIDTH(2*`SDAC_WORD_W), .DEPTH(`SDAC_FIFO_DEPTH)) uFifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inData(pair_reg),
    .inValid(pairValid_reg),
    .inReady(fifoInReady),
    .outData(sampleData),
    .outValid(sampleValid),
    .outReady(sampleReady)
  );

  // Frame rate reference for the loop: lr_clock synchronised, edge pulse;
  // reset high so a level already high at release is no false rise
  logic [2:0] lrSync_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lrSync_reg <= 3'h7;
      frameTick <= 1'b0;
    end else begin
      lrSync_reg <= {lrSync_reg[1:0], lr_clock};
      frameTick <= lrSync_reg[1] && !lrSync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control port: both control_shift_clock and strobe are oversampled
  // here, so the control clock must be slower than clk_sys / 2
  logic [2:0] shiftClkSync_reg;
  logic [1:0] cdatSync_reg;
  logic [2:0] strbSync_reg;
  logic [1:0] pdSync_reg;
  logic [`SDAC_CTL_W-1:0] ctlShift_reg;
  logic ctlRight_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shiftClkSync_reg <= 3'h0;
      cdatSync_reg <= 2'h0;
      strbSync_reg <= 3'h0;
      pdSync_reg <= 2'h0;
    end else begin
      shiftClkSync_reg <= {shiftClkSync_reg[1:0], control_shift_clock};
      cdatSync_reg <= {cdatSync_reg[0], control_serial_in};
      strbSync_reg <= {strbSync_reg[1:0], control_load_strobe};
      pdSync_reg <= {pdSync_reg[0], powerdown_reset_n};
    end
  end

  // Data passes as many stages as the clock, so it is the bit seen at the edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctlShift_reg <= `SDAC_ATTEN_RST;
    end else if (!pdSync_reg[1]) begin
      ctlShift_reg <= `SDAC_ATTEN_RST;
    end else if (shiftClkSync_reg[1] && !shiftClkSync_reg[2]) begin
      ctlShift_reg <= {ctlShift_reg[`SDAC_CTL_W-2:0], cdatSync_reg[1]};
    end
  end

  // Words alternate left then right; reset restarts at left
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      channelSetting <= {`SDAC_ATTEN_RST, `SDAC_ATTEN_RST};
      ctlRight_reg <= 1'b0;
    end else if (!pdSync_reg[1]) begin
      channelSetting <= {`SDAC_ATTEN_RST, `SDAC_ATTEN_RST};
      ctlRight_reg <= 1'b0;
    end else if (strbSync_reg[1] && !strbSync_reg[2]) begin
      if (ctlRight_reg) begin
        channelSetting.right <= ctlShift_reg;
      end else begin
        channelSetting.left <= ctlShift_reg;
      end
      ctlRight_reg <= ~ctlRight_reg;
    end
  end
endmodule
`default_nettype wire
